//--- irq_ctrl_regs.svh
// register offsets, field positions, reset values and vectors of the interrupt control block
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH
`define ICF_ADDR_BANK0 8'h0b
`define ICF_ADDR_BANK1 8'h8b
`define PIRF_ADDR 8'h0c
`define PIEN_ADDR 8'h8c
`define ICF_GIE_BIT 7
`define ICF_PERIPHERAL_GROUP_ENABLE_BIT 6
`define ICF_TOIE_BIT 5
`define ICF_INTE_BIT 4
`define ICF_RBIE_BIT 3
`define ICF_TOIF_BIT 2
`define ICF_EDGE_IRQ_FLAG_BIT 1
`define ICF_PORT_CHANGE_FLAG_BIT 0
`define CMP_BIT 6
`define PER_IMPL_MASK 8'h40
`define ICF_RESET 8'h00
`define PER_RESET 8'h00
`define RESET_VECTOR 13'h0000
`define IRQ_VECTOR 13'h0004
`endif

//--- irq_ctrl_pkg.sv
// types shared by the interrupt control block
package irq_ctrl_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic timer_zero_overflow;
		logic edge_irq_pin;
		logic [3:0] port_b_upper_pins;
		logic comparator_out;
	} event_in_t;
	typedef enum logic [1:0] {
		PC_RUN,
		PC_VECTOR
	} pc_state_t;
endpackage

//--- irq_event_detect.sv
// synchronises event inputs and turns them into one-cycle condition pulses
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
module irq_event_detect (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic edge_rising,
	input wire irq_ctrl_pkg::event_in_t events,
	output logic timer_pulse,
	output logic edge_pulse,
	output logic port_pulse,
	output logic cmp_pulse
);
	irq_ctrl_pkg::event_in_t sync1_reg;
	irq_ctrl_pkg::event_in_t sync2_reg;
	irq_ctrl_pkg::event_in_t last_reg;
	logic [2:0] primed_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			last_reg <= '0;
			primed_reg <= 3'h0;
		end else begin
			sync1_reg <= events;
			sync2_reg <= sync1_reg;
			last_reg <= sync2_reg;
			primed_reg <= {primed_reg[1:0], 1'b1};
		end
	end

	// pipeline is three deep; wait until last_reg holds a real sample so pulled-up pins give no false edge
	always_comb begin
		timer_pulse = primed_reg[2] && sync2_reg.timer_zero_overflow && !last_reg.timer_zero_overflow;
		if (edge_rising) begin
			edge_pulse = primed_reg[2] && sync2_reg.edge_irq_pin && !last_reg.edge_irq_pin;
		end else begin
			edge_pulse = primed_reg[2] && !sync2_reg.edge_irq_pin && last_reg.edge_irq_pin;
		end
		port_pulse = primed_reg[2] && (sync2_reg.port_b_upper_pins != last_reg.port_b_upper_pins);
		cmp_pulse = primed_reg[2] && (sync2_reg.comparator_out != last_reg.comparator_out);
	end
endmodule // irq_event_detect

//--- irq_ctrl.sv
// interrupt control registers, request logic and program counter vectoring
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
// What this block does
// - Flags set on their condition regardless of any enable bit.
// - Bit 7 of control register is global enable gating every request.
// - Control register holds all non-comparator enables and flags, read and write.
// - Control register appears at both bank addresses with shared storage.
// - Edge pin event sets its flag; it stays until software clears it.
// - Any change on upper four port B pins sets the port-change flag.
// - Peripheral enable bit 6 enables the comparator interrupt.
// - Peripheral flag bit 6 sets when the comparator input changes.
// - Other peripheral enable and flag bits read zero and ignore writes.
// - Program counter starts at 0000h and jumps to 0004h on interrupt.
module irq_ctrl (
	input wire logic clock,
	input wire logic reset_n,
	input wire irq_ctrl_pkg::reg_req_t req,
	input wire irq_ctrl_pkg::event_in_t events,
	input wire logic edge_rising,
	input wire logic irq_ack,
	input wire logic ret_from_irq,
	input wire logic pc_load,
	input wire logic [12:0] pc_load_value,
	output logic [7:0] rdata,
	output logic irq_request,
	output logic [12:0] program_counter,
	output logic in_handler
);
	logic rst_s1_reg;
	logic rst_n_reg;
	logic [7:0] icf_reg;
	logic [7:0] icf_next;
	logic [7:0] pirf_reg;
	logic [7:0] pirf_next;
	logic [7:0] pien_reg;
	logic [7:0] pien_next;
	logic [12:0] pc_next;
	logic timer_pulse;
	logic edge_pulse;
	logic port_pulse;
	logic cmp_pulse;
	logic icf_hit;
	logic pending;
	irq_ctrl_pkg::pc_state_t pc_state_reg;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n_reg <= rst_s1_reg;
		end
	end

	irq_event_detect u_detect (
		.clock(clock),
		.rst_n(rst_n_reg),
		.edge_rising(edge_rising),
		.events(events),
		.timer_pulse(timer_pulse),
		.edge_pulse(edge_pulse),
		.port_pulse(port_pulse),
		.cmp_pulse(cmp_pulse)
	);

	assign icf_hit = req.wr && (req.addr == `ICF_ADDR_BANK0 || req.addr == `ICF_ADDR_BANK1);

	// write first, then hardware sets on top so an event never loses to a clear
	always_comb begin
		icf_next = icf_reg;
		if (icf_hit) begin
			icf_next = req.wdata;
		end
		if (timer_pulse) begin
			icf_next[`ICF_TOIF_BIT] = 1'b1;
		end
		if (edge_pulse) begin
			icf_next[`ICF_EDGE_IRQ_FLAG_BIT] = 1'b1;
		end
		if (port_pulse) begin
			icf_next[`ICF_PORT_CHANGE_FLAG_BIT] = 1'b1;
		end
		if (irq_ack && irq_request) begin
			icf_next[`ICF_GIE_BIT] = 1'b0;
		end
		if (ret_from_irq) begin
			icf_next[`ICF_GIE_BIT] = 1'b1;
		end
	end

	always_comb begin
		pirf_next = pirf_reg;
		if (req.wr && req.addr == `PIRF_ADDR) begin
			pirf_next = req.wdata & `PER_IMPL_MASK;
		end
		if (cmp_pulse) begin
			pirf_next[`CMP_BIT] = 1'b1;
		end
	end

	always_comb begin
		pien_next = pien_reg;
		if (req.wr && req.addr == `PIEN_ADDR) begin
			pien_next = req.wdata & `PER_IMPL_MASK;
		end
	end

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			icf_reg <= `ICF_RESET;
			pirf_reg <= `PER_RESET;
			pien_reg <= `PER_RESET;
		end else begin
			icf_reg <= icf_next;
			pirf_reg <= pirf_next;
			pien_reg <= pien_next;
		end
	end

	// request sees the flag in the cycle after it is set; an enable set over a stale flag fires at once
	assign pending = (icf_reg[`ICF_TOIE_BIT] && icf_reg[`ICF_TOIF_BIT])
		|| (icf_reg[`ICF_INTE_BIT] && icf_reg[`ICF_EDGE_IRQ_FLAG_BIT])
		|| (icf_reg[`ICF_RBIE_BIT] && icf_reg[`ICF_PORT_CHANGE_FLAG_BIT])
		|| (icf_reg[`ICF_PERIPHERAL_GROUP_ENABLE_BIT] && pien_reg[`CMP_BIT] && pirf_reg[`CMP_BIT]);

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= icf_next[`ICF_GIE_BIT] && pending && !(irq_ack && irq_request);
		end
	end

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				`ICF_ADDR_BANK0, `ICF_ADDR_BANK1: rdata <= icf_reg;
				`PIRF_ADDR: rdata <= pirf_reg & `PER_IMPL_MASK;
				`PIEN_ADDR: rdata <= pien_reg & `PER_IMPL_MASK;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	always_comb begin
		pc_next = program_counter;
		if (irq_ack && irq_request) begin
			pc_next = `IRQ_VECTOR;
		end else if (pc_load) begin
			pc_next = pc_load_value;
		end
	end

	always_ff @(posedge clock or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			program_counter <= `RESET_VECTOR;
			pc_state_reg <= irq_ctrl_pkg::PC_RUN;
			in_handler <= 1'b0;
		end else begin
			program_counter <= pc_next;
			case (pc_state_reg)
				irq_ctrl_pkg::PC_RUN: begin
					if (irq_ack && irq_request) begin
						pc_state_reg <= irq_ctrl_pkg::PC_VECTOR;
						in_handler <= 1'b1;
					end
				end
				irq_ctrl_pkg::PC_VECTOR: begin
					if (ret_from_irq) begin
						pc_state_reg <= irq_ctrl_pkg::PC_RUN;
						in_handler <= 1'b0;
					end
				end
				default: begin
					pc_state_reg <= irq_ctrl_pkg::PC_RUN;
					in_handler <= 1'b0;
				end
			endcase
		end
	end

	edge_flag_sets_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		edge_pulse |=> icf_reg[`ICF_EDGE_IRQ_FLAG_BIT]) else $error("edge flag not set");
	timer_flag_sets_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		timer_pulse |=> icf_reg[`ICF_TOIF_BIT]) else $error("timer flag not set");
	port_flag_sets_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		port_pulse |=> icf_reg[`ICF_PORT_CHANGE_FLAG_BIT]) else $error("port flag not set");
	cmp_flag_sets_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		cmp_pulse |=> pirf_reg[`CMP_BIT]) else $error("comparator flag not set");
	gie_gates_req_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		irq_request |-> icf_reg[`ICF_GIE_BIT] && $past(pending)) else $error("request without enables");
	req_follows_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		(icf_reg[`ICF_GIE_BIT] && pending && !irq_ack && !ret_from_irq && !req.wr) |=> irq_request)
		else $error("request missing");
	unimpl_zero_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		((pirf_reg | pien_reg) & ~`PER_IMPL_MASK) == 8'h00) else $error("unimplemented bit set");
	bank_alias_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		req.rd && req.addr == `ICF_ADDR_BANK1 |=> rdata == $past(icf_reg)) else $error("bank alias mismatch");
	vector_jump_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		irq_ack && irq_request |=> program_counter == `IRQ_VECTOR && !icf_reg[`ICF_GIE_BIT])
		else $error("vector not taken");
	set_beats_clear_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		icf_hit && !req.wdata[`ICF_EDGE_IRQ_FLAG_BIT] && edge_pulse |=> icf_reg[`ICF_EDGE_IRQ_FLAG_BIT])
		else $error("clear beat event");
	cmp_enable_a: assert property (@(posedge clock) disable iff (!rst_n_reg)
		req.wr && req.addr == `PIEN_ADDR |=> pien_reg[`CMP_BIT] == $past(req.wdata[`CMP_BIT]))
		else $error("comparator enable not stored");

	irq_taken_c: cover property (@(posedge clock) disable iff (!rst_n_reg) irq_ack && irq_request);
	cmp_irq_c: cover property (@(posedge clock) disable iff (!rst_n_reg) irq_request && pirf_reg[`CMP_BIT]);
	race_clear_c: cover property (@(posedge clock) disable iff (!rst_n_reg) icf_hit && edge_pulse);
	return_c: cover property (@(posedge clock) disable iff (!rst_n_reg) in_handler && ret_from_irq);
endmodule // irq_ctrl

//--- core_model.sv
// core-side partner model: accepts a standing interrupt request after a chosen delay
`timescale 1ns/1ns
module core_model (
	input wire logic clock,
	input wire logic irq_request,
	input wire logic [3:0] ack_delay,
	output logic irq_ack
);
	logic [3:0] wait_reg = 4'h0;
	initial irq_ack = 1'b0;
	// one ack pulse per request; the count restarts once the request drops
	always @(posedge clock) begin
		wait_reg <= irq_request ? wait_reg + 4'h1 : 4'h0;
		irq_ack <= irq_request && (wait_reg == ack_delay);
	end
endmodule // core_model

//--- mcu_interrupt_control_tb.sv
// self-checking testbench for the interrupt control block
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
module mcu_interrupt_control_tb;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	irq_ctrl_pkg::reg_req_t req = '0;
	irq_ctrl_pkg::event_in_t events = '0;
	logic edge_rising = 1'b1;
	logic ret_from_irq = 1'b0;
	logic pc_load = 1'b0;
	logic [12:0] pc_load_value = 13'h0000;
	logic [3:0] ack_delay = 4'h0;
	logic irq_ack;
	logic [7:0] rdata;
	logic irq_request;
	logic [12:0] program_counter;
	logic in_handler;
	int fails = 0;
	int comparisons = 0;

	always #50 clock = ~clock;

	irq_ctrl uut (
		.clock(clock),
		.reset_n(reset_n),
		.req(req),
		.events(events),
		.edge_rising(edge_rising),
		.irq_ack(irq_ack),
		.ret_from_irq(ret_from_irq),
		.pc_load(pc_load),
		.pc_load_value(pc_load_value),
		.rdata(rdata),
		.irq_request(irq_request),
		.program_counter(program_counter),
		.in_handler(in_handler)
	);

	core_model core (
		.clock(clock),
		.irq_request(irq_request),
		.ack_delay(ack_delay),
		.irq_ack(irq_ack)
	);

	task automatic stop_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [12:0] got, input logic [12:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		req <= {1'b1, 1'b0, a, d};
		@(posedge clock);
		req <= '0;
	endtask

	// rdata is registered and stands one cycle, so it is taken right after that edge
	task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clock);
		req <= '0;
		#1 check({5'h00, rdata}, {5'h00, exp});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wait_handler;
		int i;
		for (i = 0; i < 20 && in_handler !== 1'b1; i++) begin
			@(posedge clock);
			#1;
		end
		check({12'h000, in_handler}, 13'h0001);
	endtask

	initial begin
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		tick(10);
		check(program_counter, `RESET_VECTOR);
		reg_read(`ICF_ADDR_BANK0, `ICF_RESET);
		reg_read(`PIRF_ADDR, `PER_RESET);
		reg_read(`PIEN_ADDR, `PER_RESET);
		@(posedge clock);
		pc_load <= 1'b1;
		pc_load_value <= 13'h0123;
		@(posedge clock);
		pc_load <= 1'b0;
		#1 check(program_counter, 13'h0123);
		reg_write(`ICF_ADDR_BANK0, 8'h78);
		reg_read(`ICF_ADDR_BANK1, 8'h78);
		reg_write(`ICF_ADDR_BANK1, 8'h00);
		reg_read(`ICF_ADDR_BANK0, 8'h00);
		reg_write(`PIRF_ADDR, 8'hff);
		reg_read(`PIRF_ADDR, `PER_IMPL_MASK);
		reg_write(`PIRF_ADDR, 8'h00);
		reg_read(`PIRF_ADDR, 8'h00);
		reg_write(`PIEN_ADDR, 8'hff);
		reg_read(`PIEN_ADDR, `PER_IMPL_MASK);
		reg_write(8'h0d, 8'hff);
		reg_read(8'h0d, 8'h00);
		// enables on, global off: flags must still latch but nothing is requested
		reg_write(`ICF_ADDR_BANK0, 8'h78);
		@(posedge clock);
		events <= 7'h63;
		tick(6);
		check({12'h000, irq_request}, 13'h0000);
		reg_read(`ICF_ADDR_BANK0, 8'h7f);
		reg_read(`PIRF_ADDR, 8'h40);
		@(posedge clock);
		edge_rising <= 1'b0;
		reg_write(`ICF_ADDR_BANK0, 8'h00);
		reg_write(`PIRF_ADDR, 8'h00);
		reg_read(`ICF_ADDR_BANK0, 8'h00);
		reg_read(`PIRF_ADDR, 8'h00);
		reg_write(`ICF_ADDR_BANK0, 8'h90);
		@(posedge clock);
		events.edge_irq_pin <= 1'b0;
		wait_handler;
		check(program_counter, `IRQ_VECTOR);
		reg_read(`ICF_ADDR_BANK0, 8'h12);
		reg_write(`ICF_ADDR_BANK0, 8'h10);
		@(posedge clock);
		ret_from_irq <= 1'b1;
		ack_delay <= 4'h3;
		@(posedge clock);
		ret_from_irq <= 1'b0;
		reg_read(`ICF_ADDR_BANK0, 8'h90);
		check({12'h000, in_handler}, 13'h0000);
		// comparator needs the group enable as well as its own enable
		reg_write(`ICF_ADDR_BANK0, 8'h80);
		@(posedge clock);
		events.comparator_out <= 1'b0;
		tick(6);
		check({12'h000, irq_request}, 13'h0000);
		reg_write(`ICF_ADDR_BANK0, 8'hc0);
		wait_handler;
		stop_test;
	end

	// the sequence needs about a hundred and ten cycles; this margin only catches a hang
	initial begin
		repeat (3000) @(posedge clock);
		fails++;
		stop_test;
	end
endmodule // mcu_interrupt_control_tb
